// ### design/ipcl_defs.svh
// register indexes, read masks, fixed read values, field positions and key tables
`ifndef IPCL_DEFS_SVH
`define IPCL_DEFS_SVH

`define IPCL_IDX_CARD_SEL    8'h06
`define IPCL_IDX_IO_HIGH     8'h60
`define IPCL_IDX_IO_LOW      8'h61
`define IPCL_IDX_IRQ_LEVEL   8'h70
`define IPCL_IDX_IRQ_KIND    8'h71
`define IPCL_IDX_DMA_A       8'h74
`define IPCL_IDX_DMA_B       8'h75
`define IPCL_IDX_CFG0        8'hF0
`define IPCL_IDX_CFG1        8'hF1
`define IPCL_IDX_CFG2        8'hF2
`define IPCL_IDX_CFG3        8'hF3
`define IPCL_IDX_SAVED_SEL   8'hF5
`define IPCL_IDX_VENDOR_CMD  8'hF6

`define IPCL_IO_HIGH_RW_MASK 8'h03
`define IPCL_IO_LOW_RW_MASK  8'hE0
`define IPCL_IRQ_LEVEL_MASK  8'h0F
`define IPCL_IRQ_KIND_VAL    8'h02
`define IPCL_DMA_NONE_VAL    8'h04
`define IPCL_VCMD_CLR_SEL    2

`define IPCL_C1_IRQ_EN       7
`define IPCL_C2_BOOT_DIS     5
`define IPCL_C3_AUTOCFG      7
`define IPCL_C3_SLEEP        2

`define IPCL_KEY_LEN         32
`define IPCL_KEY_PLUGPLAY 256'h6AB5DAEDF6FB7DBEDF6F371B0D86C361B0582C168B45A2D1E8743A9DCEE77339
`define IPCL_KEY_VENDOR   256'hDA6D361B8D46239148A4D269349A4D26138944A2512894CA6532190C8643A150

`endif

// ### design/ipcl_pkg.sv
// types shared by the configuration logic
package ipcl_pkg;
   typedef enum logic [1:0] {
      IPCL_MODE_JUMPER  = 2'b00,
      IPCL_MODE_VENDOR  = 2'b01,
      IPCL_MODE_AUTOCFG = 2'b11
   } ipcl_mode_e;

   typedef enum logic [1:0] {
      IPCL_WAIT_KEY = 2'b00,
      IPCL_CONFIG   = 2'b01
   } ipcl_state_e;

   typedef logic [7:0] ipcl_byte_t;
endpackage : ipcl_pkg

// ### design/isa_pnp_config_logic.sv
// plug and play configuration register bank with initiation key decode
// Overview of operation
// RULE1: io base high: bits 7..2 read zero
// RULE2: io base low: bits 4..0 read zero
// RULE3: four-bit interrupt level selects line 1-15
// RULE4: level zero drives no interrupt line
// RULE5: interrupt type reads 02, read only
// RULE6: both dma selects read 04, read only
// RULE7: F0-F3 mirror the four configuration bytes
// RULE8: F5 returns the saved select number
// RULE9: F6 bit2 clears select number, self-clearing
// RULE10: mode from jumper pin, autoconfig pin, eeprom bit
// RULE11: defaults from jumpers or from eeprom per mode
// RULE12: register writes update configuration byte fields
// RULE13: auto-load or drive-reset restores power-up defaults
// RULE14: boot rom size never changed by software
// RULE15: vendor key always; standard key only autoconfig
// RULE16: vendor key opens config state in any mode
// RULE17: reset defaults: irq enable 1, bootrom enable
// RULE18: logic inactive until 32-byte key written
// RULE19: complete key enables configuration ports
// RULE20: key mismatch restarts matcher at first byte
// RULE21: standard key sequence 6A B5 ... 73 39
// RULE22: select number write also sets saved copy
// RULE23: five-bit position counter, done after 32nd
// RULE24: unlisted or write-only indexes read zero
`include "ipcl_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module isa_pnp_config_logic (
   // clock and drive-reset
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // host port strobes
   input  wire logic                 addrPortWr,
   input  wire logic                 dataPortWr,
   input  wire logic                 dataPortRd,
   input  wire ipcl_pkg::ipcl_byte_t hostWrData,
   output var  ipcl_pkg::ipcl_byte_t hostRdData,
   // mode straps and power-up sources
   input  wire logic                 jumperModePin,
   input  wire logic                 autoconfigModeSelect,
   input  wire logic                 eepromAutoconfigBit,
   input  wire logic                 autoLoad,
   input  wire ipcl_pkg::ipcl_byte_t cfgByte0In,
   input  wire ipcl_pkg::ipcl_byte_t jumperCfg1,
   input  wire ipcl_pkg::ipcl_byte_t jumperCfg2,
   input  wire ipcl_pkg::ipcl_byte_t eepromCfg1,
   input  wire ipcl_pkg::ipcl_byte_t eepromCfg2,
   input  wire ipcl_pkg::ipcl_byte_t eepromCfg3,
   // interrupt request from the controller core
   input  wire logic                 coreIrq,
   output logic [15:0]               irqLines,
   // configuration state to the controller core
   output ipcl_pkg::ipcl_mode_e      cfgMode,
   output logic                      cfgActive,
   output ipcl_pkg::ipcl_byte_t      cfgByte1,
   output ipcl_pkg::ipcl_byte_t      cfgByte2,
   output ipcl_pkg::ipcl_byte_t      cfgByte3,
   output ipcl_pkg::ipcl_byte_t      cardSelectNumber,
   output ipcl_pkg::ipcl_byte_t      savedSelectNumber
);
   import ipcl_pkg::*;

   localparam logic [4:0] KEY_LAST = 5'(`IPCL_KEY_LEN - 1);
   localparam logic [255:0] KEY_STD = `IPCL_KEY_PLUGPLAY;
   localparam logic [255:0] KEY_VND = `IPCL_KEY_VENDOR;

   ipcl_mode_e  mode_r;
   ipcl_mode_e  mode_nxt;
   ipcl_state_e state_r;
   logic        cfgActive_r;
   ipcl_byte_t  index_r;
   ipcl_byte_t  ioHigh_r;
   ipcl_byte_t  ioLow_r;
   ipcl_byte_t  irqLevel_r;
   ipcl_byte_t  cfg1_r;
   ipcl_byte_t  cfg2_r;
   ipcl_byte_t  cfg3_r;
   ipcl_byte_t  cfg1Def;
   ipcl_byte_t  cfg2Def;
   ipcl_byte_t  cfg3Def;
   ipcl_byte_t  cardSel_r;
   ipcl_byte_t  savedSel_r;
   ipcl_byte_t  rdData_r;
   logic [15:0] irqLines_r;
   logic [4:0]  stdPos_r;
   logic [4:0]  vndPos_r;
   logic        stdHit;
   logic        vndHit;
   logic        cfgWr;
   logic        loadDefaults;

   function automatic ipcl_byte_t keyByte(input logic [255:0] key,
                                          input logic [4:0]   pos);
      keyByte = key[8'(255 - 8 * pos) -: 8];
   endfunction : keyByte

   // mode resolved combinationally, latched with the defaults
   always_comb begin
      if (jumperModePin) begin
         mode_nxt = IPCL_MODE_JUMPER;                               // [RULE10]
      end else if (autoconfigModeSelect || eepromAutoconfigBit) begin
         mode_nxt = IPCL_MODE_AUTOCFG;                              // [RULE10]
      end else begin
         mode_nxt = IPCL_MODE_VENDOR;                               // [RULE10]
      end
   end

   // power-up images of the three setup bytes
   always_comb begin
      if (mode_nxt == IPCL_MODE_JUMPER) begin
         cfg1Def = {1'b1, jumperCfg1[6:0]};                         // [RULE11]
         cfg2Def = {jumperCfg2[7:6], 1'b0, jumperCfg2[4:0]};        // [RULE11]
      end else begin
         cfg1Def = {1'b1, eepromCfg1[6:0]};                         // [RULE11]
         cfg2Def = {eepromCfg2[7:6], 1'b0, eepromCfg2[4:0]};        // [RULE11]
      end
      // irq enable forced on, boot rom select left enabled
      cfg1Def[`IPCL_C1_IRQ_EN] = 1'b1;                              // [RULE17]
      cfg2Def[`IPCL_C2_BOOT_DIS] = 1'b0;                            // [RULE17]
      cfg3Def = {(mode_nxt == IPCL_MODE_AUTOCFG), eepromCfg3[6:4],
                 1'b0, 1'b0, eepromCfg3[1:0]};                      // [RULE17]
   end

   assign loadDefaults = srst || autoLoad;
   assign cfgWr = dataPortWr && (state_r == IPCL_CONFIG);
   assign stdHit = (hostWrData == keyByte(KEY_STD, stdPos_r));
   assign vndHit = (hostWrData == keyByte(KEY_VND, vndPos_r));

   always_ff @(posedge mclk) begin
      if (loadDefaults) begin
         mode_r <= mode_nxt;
      end
   end

   // key matchers: one position counter per key
   always_ff @(posedge mclk) begin
      if (srst || state_r == IPCL_CONFIG) begin
         stdPos_r <= 5'h00;
         vndPos_r <= 5'h00;
      end else if (addrPortWr) begin
         // a wrong byte throws the whole sequence away
         stdPos_r <= stdHit ? stdPos_r + 5'h01 : 5'h00;             // [RULE20] [RULE23]
         vndPos_r <= vndHit ? vndPos_r + 5'h01 : 5'h00;             // [RULE20] [RULE23]
      end
   end

   // config state entered only by a complete key
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r     <= IPCL_WAIT_KEY;                              // [RULE18]
         cfgActive_r <= 1'b0;                                       // [RULE18]
      end else if (state_r == IPCL_WAIT_KEY && addrPortWr) begin
         // flag kept beside the state so the output is a flop
         if (vndHit && vndPos_r == KEY_LAST) begin
            state_r     <= IPCL_CONFIG;                             // [RULE15] [RULE16] [RULE19]
            cfgActive_r <= 1'b1;                                    // [RULE19]
         end else if (stdHit && stdPos_r == KEY_LAST &&
                      mode_r == IPCL_MODE_AUTOCFG) begin
            state_r     <= IPCL_CONFIG;                             // [RULE15] [RULE19] [RULE21]
            cfgActive_r <= 1'b1;                                    // [RULE19]
         end
      end
   end

   // address port selects the register index once configured
   always_ff @(posedge mclk) begin
      if (srst) begin
         index_r <= 8'h00;
      end else if (addrPortWr && state_r == IPCL_CONFIG) begin
         index_r <= hostWrData;
      end
   end

   // io base, interrupt level and the setup bytes they feed
   always_ff @(posedge mclk) begin
      if (loadDefaults) begin
         cfg1_r     <= cfg1Def;                                     // [RULE13]
         cfg2_r     <= cfg2Def;                                     // [RULE13]
         cfg3_r     <= cfg3Def;                                     // [RULE13]
         ioHigh_r   <= {6'h00, cfg1Def[3:2]};                       // [RULE13]
         ioLow_r    <= {cfg1Def[1:0], 6'h00};                       // [RULE13]
         irqLevel_r <= {5'h00, cfg1Def[6:4]};                       // [RULE13]
      end else if (cfgWr) begin
         unique case (index_r)
            `IPCL_IDX_IO_HIGH: begin
               ioHigh_r <= hostWrData & `IPCL_IO_HIGH_RW_MASK;      // [RULE1]
               cfg1_r[3:2] <= hostWrData[1:0];                      // [RULE12]
            end
            `IPCL_IDX_IO_LOW: begin
               ioLow_r <= hostWrData & `IPCL_IO_LOW_RW_MASK;        // [RULE2]
               cfg1_r[1:0] <= hostWrData[7:6];                      // [RULE12]
            end
            `IPCL_IDX_IRQ_LEVEL: begin
               irqLevel_r <= hostWrData & `IPCL_IRQ_LEVEL_MASK;     // [RULE3]
               cfg1_r[6:4] <= hostWrData[2:0];                      // [RULE12]
            end
            // cfg2 boot rom size has no write path at all
            default: begin                                          // [RULE14]
            end
         endcase
      end
   end

   // card select number and its saved copy
   always_ff @(posedge mclk) begin
      if (srst) begin
         cardSel_r  <= 8'h00;
         savedSel_r <= 8'h00;
      end else if (cfgWr && index_r == `IPCL_IDX_CARD_SEL) begin
         cardSel_r  <= hostWrData;                                  // [RULE22]
         savedSel_r <= hostWrData;                                  // [RULE22]
      end else if (cfgWr && index_r == `IPCL_IDX_VENDOR_CMD &&
                   hostWrData[`IPCL_VCMD_CLR_SEL]) begin
         // command bit is never stored, so it reads back cleared
         cardSel_r <= 8'h00;                                        // [RULE9]
      end
   end

   // read mux, registered; outside config state the port is silent
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdData_r <= 8'h00;
      end else if (dataPortRd) begin
         if (state_r != IPCL_CONFIG) begin
            rdData_r <= 8'h00;                                      // [RULE18]
         end else begin
            unique case (index_r)
               `IPCL_IDX_CARD_SEL:  rdData_r <= cardSel_r;
               `IPCL_IDX_IO_HIGH:   rdData_r <= ioHigh_r;           // [RULE1]
               `IPCL_IDX_IO_LOW:    rdData_r <= ioLow_r;            // [RULE2]
               `IPCL_IDX_IRQ_LEVEL: rdData_r <= irqLevel_r;         // [RULE3]
               `IPCL_IDX_IRQ_KIND:  rdData_r <= `IPCL_IRQ_KIND_VAL; // [RULE5]
               `IPCL_IDX_DMA_A:     rdData_r <= `IPCL_DMA_NONE_VAL; // [RULE6]
               `IPCL_IDX_DMA_B:     rdData_r <= `IPCL_DMA_NONE_VAL; // [RULE6]
               `IPCL_IDX_CFG0:      rdData_r <= cfgByte0In;         // [RULE7]
               `IPCL_IDX_CFG1:      rdData_r <= cfg1_r;             // [RULE7]
               `IPCL_IDX_CFG2:      rdData_r <= cfg2_r;             // [RULE7]
               `IPCL_IDX_CFG3:      rdData_r <= cfg3_r;             // [RULE7]
               `IPCL_IDX_SAVED_SEL: rdData_r <= savedSel_r;         // [RULE8]
               default:             rdData_r <= 8'h00;              // [RULE24]
            endcase
         end
      end
   end

   // one-hot interrupt steering; line 0 never used
   always_ff @(posedge mclk) begin
      if (srst) begin
         irqLines_r <= 16'h0000;
      end else if (coreIrq && cfg1_r[`IPCL_C1_IRQ_EN] &&
                   irqLevel_r[3:0] != 4'h0) begin
         irqLines_r <= 16'h0001 << irqLevel_r[3:0];                 // [RULE3]
      end else begin
         irqLines_r <= 16'h0000;                                    // [RULE4]
      end
   end

   assign hostRdData        = rdData_r;
   assign irqLines          = irqLines_r;
   assign cfgMode           = mode_r;
   assign cfgActive         = cfgActive_r;
   assign cfgByte1          = cfg1_r;
   assign cfgByte2          = cfg2_r;
   assign cfgByte3          = cfg3_r;
   assign cardSelectNumber  = cardSel_r;
   assign savedSelectNumber = savedSel_r;
endmodule : isa_pnp_config_logic

`default_nettype wire

// ### verification/ipcl_host_model.sv
// host model for the address, write-data and read-data ports
`timescale 1ns/10ps
`default_nettype none
module ipcl_host_model (
   // clock
   input  wire logic                 mclk,
   // host strobes and data
   output logic                      addrPortWr,
   output logic                      dataPortWr,
   output logic                      dataPortRd,
   output ipcl_pkg::ipcl_byte_t      hostWrData,
   input  wire ipcl_pkg::ipcl_byte_t hostRdData
);
   import ipcl_pkg::*;
   initial {addrPortWr, dataPortWr, dataPortRd, hostWrData} = 11'h000;
   // k selects the port: 0 address, 1 write data, 2 read data
   task automatic strobe(input int k, input ipcl_byte_t b);
      @(posedge mclk);
      hostWrData <= b;
      addrPortWr <= (k == 0);
      dataPortWr <= (k == 1);
      dataPortRd <= (k == 2);
      @(posedge mclk);
      {addrPortWr, dataPortWr, dataPortRd} <= 3'b000;
      // released bus shows no stale byte
      hostWrData <= ~b;
   endtask : strobe
   task automatic rd(input ipcl_byte_t idx, output ipcl_byte_t b);
      strobe(0, idx);
      strobe(2, 8'h00);
      #1 b = hostRdData;
   endtask : rd
   // first n key bytes in table order
   task automatic send_key(input logic [255:0] key, input int n);
      for (int i = 31; i >= 32 - n; i--) begin
         strobe(0, key[i*8 +: 8]);
      end
   endtask : send_key
endmodule : ipcl_host_model
`default_nettype wire

// ### verification/ipcl_properties.sv
// concurrent checks on the configuration logic ports
`timescale 1ns/10ps
`default_nettype none
module ipcl_properties (
   // clock and reset
   input wire logic                 mclk,
   input wire logic                 srst,
   // watched ports
   input wire logic                 dataPortRd,
   input wire logic                 autoLoad,
   input wire logic                 jumperModePin,
   input wire logic                 autoconfigModeSelect,
   input wire logic                 eepromAutoconfigBit,
   input wire ipcl_pkg::ipcl_byte_t hostRdData,
   input wire logic [15:0]          irqLines,
   input wire ipcl_pkg::ipcl_mode_e cfgMode,
   input wire logic                 cfgActive,
   input wire ipcl_pkg::ipcl_byte_t cfgByte1,
   input wire ipcl_pkg::ipcl_byte_t cfgByte2,
   input wire ipcl_pkg::ipcl_byte_t cardSelectNumber,
   input wire ipcl_pkg::ipcl_byte_t savedSelectNumber
);
   import ipcl_pkg::*;
   ipcl_mode_e modeExp;
   logic       reload;
   assign modeExp = jumperModePin ? IPCL_MODE_JUMPER :
      (autoconfigModeSelect | eepromAutoconfigBit) ? IPCL_MODE_AUTOCFG :
      IPCL_MODE_VENDOR;
   assign reload = srst | autoLoad;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   AST_MODE: assert property ($past(reload) |->
      cfgMode == $past(modeExp)) else $error("mode decode wrong");
   AST_DEFAULTS: assert property (
      $past(reload) && cfgMode != IPCL_MODE_AUTOCFG |->
      cfgByte1[7] && !cfgByte2[5]) else $error("reload defaults wrong");
   AST_BOOTROM: assert property (!$past(reload) |->
      $stable(cfgByte2[4:0])) else $error("boot rom size changed");
   AST_IRQ: assert property ($onehot0(irqLines) && !irqLines[0])
      else $error("irq lines bad");
   AST_RDOFF: assert property (dataPortRd && !cfgActive |=>
      hostRdData == 8'h00) else $error("read before key not zero");
   AST_RDHOLD: assert property (!dataPortRd |=> $stable(hostRdData))
      else $error("read data moved");
   AST_ACTIVE: assert property (cfgActive |=> cfgActive)
      else $error("config state left");
   AST_SAVED: assert property (!$stable(savedSelectNumber) |->
      savedSelectNumber == cardSelectNumber) else $error("saved copy wrong");
endmodule : ipcl_properties
bind isa_pnp_config_logic ipcl_properties u_props (
   .mclk(mclk), .srst(srst), .dataPortRd(dataPortRd), .autoLoad(autoLoad),
   .jumperModePin(jumperModePin), .autoconfigModeSelect(autoconfigModeSelect),
   .eepromAutoconfigBit(eepromAutoconfigBit), .hostRdData(hostRdData),
   .irqLines(irqLines), .cfgMode(cfgMode), .cfgActive(cfgActive),
   .cfgByte1(cfgByte1), .cfgByte2(cfgByte2),
   .cardSelectNumber(cardSelectNumber),
   .savedSelectNumber(savedSelectNumber));
`default_nettype wire

// ### verification/isa_pnp_config_logic_bench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "ipcl_defs.svh"
module isa_pnp_config_logic_bench;
   import ipcl_pkg::*;
   logic       mclk, srst, addrPortWr, dataPortWr, dataPortRd, autoLoad;
   logic       jumperModePin, autoconfigModeSelect, eepromAutoconfigBit;
   logic       coreIrq, cfgActive;
   logic [15:0] irqLines, eI;
   ipcl_mode_e cfgMode;
   ipcl_byte_t hostWrData, hostRdData, cfgByte0In, jumperCfg1, jumperCfg2;
   ipcl_byte_t eepromCfg1, eepromCfg2, eepromCfg3, cfgByte1, cfgByte2;
   ipcl_byte_t cfgByte3, cardSelectNumber, savedSelectNumber, v, x;
   ipcl_byte_t idxs [9] = '{8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75,
                            8'hF6, 8'h33, 8'hF4};
   ipcl_byte_t dv [9];
   ipcl_byte_t lvls [4] = '{8'h00, 8'h01, 8'h0F, 8'h07};
   int         nFail = 0;
   int         testsRun = 0;
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;
   isa_pnp_config_logic i_dut (
      .mclk(mclk), .srst(srst), .addrPortWr(addrPortWr),
      .dataPortWr(dataPortWr), .dataPortRd(dataPortRd),
      .hostWrData(hostWrData), .hostRdData(hostRdData),
      .jumperModePin(jumperModePin), .autoconfigModeSelect(autoconfigModeSelect),
      .eepromAutoconfigBit(eepromAutoconfigBit), .autoLoad(autoLoad),
      .cfgByte0In(cfgByte0In), .jumperCfg1(jumperCfg1), .jumperCfg2(jumperCfg2),
      .eepromCfg1(eepromCfg1), .eepromCfg2(eepromCfg2), .eepromCfg3(eepromCfg3),
      .coreIrq(coreIrq), .irqLines(irqLines), .cfgMode(cfgMode),
      .cfgActive(cfgActive), .cfgByte1(cfgByte1), .cfgByte2(cfgByte2),
      .cfgByte3(cfgByte3), .cardSelectNumber(cardSelectNumber),
      .savedSelectNumber(savedSelectNumber));
   ipcl_host_model i_host (
      .mclk(mclk), .addrPortWr(addrPortWr), .dataPortWr(dataPortWr),
      .dataPortRd(dataPortRd), .hostWrData(hostWrData),
      .hostRdData(hostRdData));
   function automatic ipcl_mode_e expMode(input logic [2:0] m);
      return m[2] ? IPCL_MODE_JUMPER :
         (|m[1:0]) ? IPCL_MODE_AUTOCFG : IPCL_MODE_VENDOR;
   endfunction : expMode
   function automatic ipcl_byte_t expReg(input ipcl_byte_t i, ipcl_byte_t d);
      case (i)
         8'h60: return d & 8'h03;
         8'h61: return d & 8'hE0;
         8'h70: return d & 8'h0F;
         8'h71: return 8'h02;
         8'h74, 8'h75: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction : expReg
   task automatic reportAndStop();
      $display("checks %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : reportAndStop
   task automatic chk(input string nm, input ipcl_byte_t e, ipcl_byte_t g);
      testsRun++;
      if (g !== e) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic doReset(input logic [2:0] m);
      @(posedge mclk);
      {jumperModePin, autoconfigModeSelect, eepromAutoconfigBit} <= m;
      srst <= 1'b1;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
   endtask : doReset
   task automatic wrReg(input ipcl_byte_t i, input ipcl_byte_t d);
      i_host.strobe(0, i);
      i_host.strobe(1, d);
   endtask : wrReg
   task automatic rdChk(input ipcl_byte_t i, input ipcl_byte_t e);
      i_host.rd(i, v);
      chk($sformatf("index %h", i), e, v);
   endtask : rdChk
   task automatic waitAct(input logic e);
      repeat (2) @(posedge mclk);
      #1 chk("cfgActive", {7'h00, e}, {7'h00, cfgActive});
   endtask : waitAct
   initial begin
      repeat (20000) @(posedge mclk);
      nFail++;
      reportAndStop();
   end
   initial begin
      {srst, autoLoad, coreIrq} = 3'b100;
      {jumperModePin, autoconfigModeSelect, eepromAutoconfigBit} = 3'b100;
      void'($urandom(32'h4584E9AC));
      {cfgByte0In, jumperCfg1, jumperCfg2} = 24'($urandom);
      {eepromCfg1, eepromCfg2, eepromCfg3} = 24'($urandom);
      for (int m = 0; m < 8; m++) begin
         doReset(3'(m));
         #1 chk("cfgMode", {6'h00, expMode(3'(m))}, {6'h00, cfgMode});
      end
      $display("modes done");
      doReset(3'b100);
      rdChk(8'h71, 8'h00);
      i_host.send_key(`IPCL_KEY_PLUGPLAY, 32);
      waitAct(1'b0);
      i_host.send_key(`IPCL_KEY_VENDOR, 31);
      i_host.strobe(0, 8'hAF);
      i_host.strobe(0, 8'h50);
      waitAct(1'b0);
      i_host.send_key(`IPCL_KEY_VENDOR, 32);
      waitAct(1'b1);
      $display("keys done");
      foreach (idxs[i]) begin
         dv[i] = 8'($urandom);
         wrReg(idxs[i], dv[i]);
         rdChk(idxs[i], expReg(idxs[i], dv[i]));
      end
      rdChk(8'hF0, cfgByte0In);
      rdChk(8'hF1, {1'b1, dv[2][2:0], dv[0][1:0], dv[1][7:6]});
      rdChk(8'hF2, {jumperCfg2[7:6], 1'b0, jumperCfg2[4:0]});
      rdChk(8'hF3, {1'b0,eepromCfg3[6:4],2'b00,eepromCfg3[1:0]});
      x = 8'($urandom) | 8'h01;
      wrReg(8'h06, x);
      rdChk(8'hF5, x);
      wrReg(8'hF6, 8'h04);
      rdChk(8'hF5, x);
      chk("cardSelect", 8'h00, cardSelectNumber);
      wrReg(8'h06, x);
      rdChk(8'hF6, 8'h00);
      chk("cardSelect", x, cardSelectNumber);
      $display("registers done");
      @(posedge mclk) coreIrq <= 1'b1;
      foreach (lvls[i]) begin
         wrReg(8'h70, lvls[i]);
         repeat (3) @(posedge mclk);
         #1 eI = (lvls[i] == 8'h00) ? 16'h0000 : 16'h0001 << lvls[i][3:0];
         chk("irqHigh", eI[15:8], irqLines[15:8]);
         chk("irqLow", eI[7:0], irqLines[7:0]);
      end
      $display("interrupts done");
      @(posedge mclk);
      {jumperModePin, autoconfigModeSelect, eepromAutoconfigBit} <= 3'b010;
      eepromCfg1 <= 8'($urandom);
      autoLoad <= 1'b1;
      @(posedge mclk) autoLoad <= 1'b0;
      rdChk(8'h70, {5'h00, eepromCfg1[6:4]});
      chk("cfgMode", 8'h03, {6'h00, cfgMode});
      chk("bootSize", {3'h0, eepromCfg2[4:0]}, {3'h0, cfgByte2[4:0]});
      chk("cfg3Mode", 8'h01, {7'h00, cfgByte3[7]});
      doReset(3'b001);
      i_host.send_key(`IPCL_KEY_PLUGPLAY, 32);
      waitAct(1'b1);
      $display("reload done");
      reportAndStop();
   end
endmodule : isa_pnp_config_logic_bench
`default_nettype wire
